//--- hw/sch_pkg.sv
// Constants for the two-channel serial controller with host interrupt logic.
// Assumes an APB master at 50 MHz; channel A is index 0, channel B index 1.
//
// Overview of operation
// - NRZ is level; NRZI toggles on zero.
// - Biphase mark: edge each cell, mid-edge on one.
// - Biphase space: edge each cell, mid-edge on zero.
// - Auto echo copies serial input straight to output.
// - Loopback feeds transmitter to receiver, still echoes input.
// - Loopback ignores carrier and clear-to-send enables, interrupts remain.
// - Acknowledge places vector; both channels read it.
// - Status in three vector bits; B always, A never.
// - Six sources: pending, in-service, enable; master gate.
// - Pending with chain input high pulls interrupt low.
// - Channel A first; receive, transmit, external order.
// - Transmit interrupt on empty only after a write.
// - Three receive modes; first-character arms special conditions.
// - Overrun and framing errors are special.
// - External interrupt on carrier and sync pin edges, underrun, zero, break.
// - Break interrupts at start and end.
// - Wait/request output acts as wait or request.
// - Data select reaches data; else pointer; high is A.
// - Pointer bit 3 with bits 5,6 clear selects 8-15.
// - Pointer bits 0-4 clear after the indirect access.
`default_nettype none
package sch_pkg;
	// APB map: bit 2 selects the data register, bit 3 selects channel A
	localparam int          ADDR_DATA_BIT = 2;
	localparam int          ADDR_CHAN_BIT = 3;
	localparam logic [31:0] ADDR_MAP_MASK = 32'hffff_fff3;
	// Indirect register indices
	localparam logic [3:0]  REG_PTR    = 4'h0;
	localparam logic [3:0]  REG_INTR   = 4'h1;
	localparam logic [3:0]  REG_VEC    = 4'h2;
	localparam logic [3:0]  REG_RXCTL  = 4'h3;
	localparam logic [3:0]  REG_DATA   = 4'h8;
	localparam logic [3:0]  REG_MASTER = 4'h9;
	localparam logic [3:0]  REG_CODING = 4'ha;
	localparam logic [3:0]  REG_MISC   = 4'he;
	localparam logic [3:0]  REG_EXTIE  = 4'hf;
	localparam logic [7:0]  REG_RESET  = 8'h00;
	// Pointer register fields and commands
	localparam int          PTR_HIGH = 3;
	localparam int          PTR_X5   = 5;
	localparam int          PTR_X6   = 6;
	localparam logic [7:0]  PTR_KEEP = 8'he0;
	localparam int          CMD_LO   = 3;
	localparam logic [2:0]  CMD_RST_EXT  = 3'h2;
	localparam logic [2:0]  CMD_EN_FIRST = 3'h4;
	localparam logic [2:0]  CMD_RST_TXP  = 3'h5;
	localparam logic [2:0]  CMD_ERR_RST  = 3'h6;
	localparam logic [2:0]  CMD_RST_IUS  = 3'h7;
	// Interrupt/transfer control fields
	localparam int          EXT_IE = 0;
	localparam int          TX_IE = 1;
	localparam int          RXM_LO = 3;
	localparam int          WREQ_ON_RX = 5;
	localparam int          WREQ_FUNC = 6;
	localparam int          WREQ_EN = 7;
	localparam logic [1:0]  RXM_FIRST = 2'h1;
	localparam logic [1:0]  RXM_ALL = 2'h2;
	localparam logic [1:0]  RXM_SPECIAL = 2'h3;
	// Enables, master control, coding, loop control, external enables
	localparam int          RX_EN = 0;
	localparam int          TX_EN = 3;
	localparam int          AUTO_EN = 5;
	localparam int          VIS = 0;
	localparam int          MASTER_INTR_ENABLE = 3;
	localparam int          CODE_LO = 5;
	localparam logic [1:0]  CODE_NRZ = 2'h0;
	localparam logic [1:0]  CODE_NRZI = 2'h1;
	localparam logic [1:0]  CODE_MARK = 2'h2;
	localparam logic [1:0]  CODE_SPACE = 2'h3;
	localparam int          ECHO = 3;
	localparam int          LOOP = 4;
	localparam int          BIPHASE_RX = 5;
	localparam int          ZC_IE = 1;
	localparam int          CD_IE = 3;
	localparam int          SYNC_IE = 4;
	localparam int          UNDER_IE = 6;
	localparam int          BREAK_IE = 7;
	// Status codes placed in vector bits 3:1
	localparam int          VEC_ST_LO = 1;
	localparam logic [2:0]  ST_B_TX = 3'h0;
	localparam logic [2:0]  ST_B_EXT = 3'h1;
	localparam logic [2:0]  ST_B_RX = 3'h2;
	localparam logic [2:0]  ST_B_SP = 3'h3;
	localparam logic [2:0]  ST_A_TX = 3'h4;
	localparam logic [2:0]  ST_A_EXT = 3'h5;
	localparam logic [2:0]  ST_A_RX = 3'h6;
	localparam logic [2:0]  ST_A_SP = 3'h7;
	// Bit cell timing
	localparam int          CLK_NS = 20;
	localparam int          BIT_NS = 2000;
	localparam int          CELL_CYC = BIT_NS / CLK_NS;
	localparam int          CNT_W = 7;
	localparam logic [CNT_W-1:0] CELL_LAST = CNT_W'(CELL_CYC - 1);
	localparam logic [CNT_W-1:0] CELL_HALF = CNT_W'(CELL_CYC / 2);
	localparam logic [CNT_W-1:0] CELL_Q1 = CNT_W'(CELL_CYC / 4);
	localparam logic [CNT_W-1:0] CELL_Q3 = CNT_W'((CELL_CYC * 3) / 4);
	localparam logic [3:0]  TX_FRAME_REST = 4'h9;
	localparam logic [3:0]  RX_STOP_IDX = 4'h8;
	typedef enum logic {RX_HUNT, RX_DATA} sch_rx_state_t;
endpackage : sch_pkg
`default_nettype wire

//--- hw/sch_top.sv
// Two serial channels with line coding, echo/loopback, interrupt logic and wait/request.
// Assumes an APB master on pclk; serial and strobe inputs are synchronous to pclk.
`default_nettype none
module sch_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd_in_a,
	input  wire logic        rxd_in_b,
	output logic             txd_out_a,
	output logic             txd_out_b,
	input  wire logic        carrier_detect_in_a,
	input  wire logic        carrier_detect_in_b,
	input  wire logic        cts_in_a,
	input  wire logic        cts_in_b,
	input  wire logic        sync_pin_a,
	input  wire logic        sync_pin_b,
	input  wire logic        intr_ack_in,
	input  wire logic        daisy_chain_in,
	output logic             daisy_chain_out,
	output logic             intr_n,
	output logic      [7:0]  intr_vector_out,
	output logic             wait_req_n_a,
	output logic             wait_req_n_b
);
	// Indirect index from the pointer
	function automatic logic [3:0] reg_index(input logic [7:0] p);
		reg_index = {p[sch_pkg::PTR_HIGH] & ~p[sch_pkg::PTR_X5] & ~p[sch_pkg::PTR_X6], p[2:0]};
	endfunction : reg_index

	// Highest set bit in the order A rx, A tx, A ext, B rx, B tx, B ext
	function automatic logic [5:0] top_of(input logic [5:0] v);
		top_of = '0;
		for (int i = 0; i < 6; i++) begin
			if (v[i])
				top_of = 6'h01 << i;
		end
	endfunction : top_of

	// Status code of the winning source
	function automatic logic [2:0] status_of(input logic [5:0] t, input logic sp_a, input logic sp_b);
		case (t)
			6'h20:   status_of = sp_a ? sch_pkg::ST_A_SP : sch_pkg::ST_A_RX;
			6'h10:   status_of = sch_pkg::ST_A_TX;
			6'h08:   status_of = sch_pkg::ST_A_EXT;
			6'h04:   status_of = sp_b ? sch_pkg::ST_B_SP : sch_pkg::ST_B_RX;
			6'h02:   status_of = sch_pkg::ST_B_TX;
			6'h01:   status_of = sch_pkg::ST_B_EXT;
			default: status_of = sch_pkg::ST_B_SP;
		endcase
	endfunction : status_of

	// Next line level for one encoding step; start marks the cell boundary
	function automatic logic enc(input logic [1:0] code, input logic start, input logic b, input logic line);
		case (code)
			sch_pkg::CODE_NRZ:   enc = start ? b : line;
			sch_pkg::CODE_NRZI:  enc = start ? line ^ ~b : line;
			sch_pkg::CODE_MARK:  enc = start ? ~line : line ^ b;
			default:             enc = start ? ~line : line ^ ~b;
		endcase
	endfunction : enc

	logic [1:0]       rxd_v, cd_v, cts_v, syn_v, txd_v, wrn_v, stall_v, sp_v;
	logic [1:0][7:0]  ptr_v, rr0_v, rr1_v, rxbuf_v, extie_v;
	logic [1:0][2:0]  ip_v;
	logic [7:0]       vec;
	logic [7:0]       master;
	logic [5:0]       intr_under_service_bit;
	logic             ack_q;
	logic [31:0]      rd_val;

	assign rxd_v = {rxd_in_b, rxd_in_a};
	assign cd_v  = {carrier_detect_in_b, carrier_detect_in_a};
	assign cts_v = {cts_in_b, cts_in_a};
	assign syn_v = {sync_pin_b, sync_pin_a};
	assign txd_out_a = txd_v[0];
	assign txd_out_b = txd_v[1];
	assign wait_req_n_a = wrn_v[0];
	assign wait_req_n_b = wrn_v[1];

	// Bus decode: high channel select means A, data select bypasses the pointer
	logic       cur_ch, is_data, mapped, done, wr_go, rd_go;
	logic [3:0] cur_idx;
	logic [5:0] ip_all, ip_top;
	logic [2:0] cur_status;
	assign cur_ch  = ~paddr[sch_pkg::ADDR_CHAN_BIT];
	assign is_data = paddr[sch_pkg::ADDR_DATA_BIT];
	assign mapped  = (paddr & sch_pkg::ADDR_MAP_MASK) == '0;
	assign cur_idx = is_data ? sch_pkg::REG_DATA : reg_index(ptr_v[cur_ch]);
	assign done    = psel & penable & pready;
	assign wr_go   = done & pwrite & mapped;
	assign rd_go   = done & ~pwrite & mapped;
	assign ip_all  = {ip_v[0], ip_v[1]};
	assign ip_top  = top_of(ip_all);
	assign cur_status = status_of(ip_top, sp_v[0], sp_v[1]);

	// Read mux; images of 0-3 repeat at 4-7
	always_comb begin
		rd_val = '0;
		if (cur_idx == sch_pkg::REG_DATA) begin
			rd_val[7:0] = rxbuf_v[cur_ch];
		end else if (cur_idx == sch_pkg::REG_EXTIE) begin
			rd_val[7:0] = extie_v[cur_ch];
		end else if (!cur_idx[3]) begin
			case (cur_idx[1:0])
				2'h0:    rd_val[7:0] = rr0_v[cur_ch];
				2'h1:    rd_val[7:0] = rr1_v[cur_ch];
				2'h2:    rd_val[7:0] = cur_ch ? {vec[7:4], cur_status, vec[0]} : vec;
				default: rd_val[7:0] = cur_ch ? 8'h00 : {2'h0, ip_all};
			endcase
		end
	end

	// APB answer one cycle into the access phase; a wait-mode data access stretches it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready & ~(mapped & is_data & stall_v[cur_ch]);
			prdata <= rd_val;
			pslverr <= psel & penable & ~pready & ~mapped;
		end
	end

	// Shared vector and master control, writable through either channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec <= sch_pkg::REG_RESET;
			master <= sch_pkg::REG_RESET;
		end else if (wr_go && !is_data) begin
			if (cur_idx == sch_pkg::REG_VEC)
				vec <= pwdata[7:0];
			if (cur_idx == sch_pkg::REG_MASTER)
				master <= pwdata[7:0];
		end
	end

	// In-service bits: acknowledge sets the winner, command clears the highest; set wins
	logic       ack_ev, ius_rst;
	logic [5:0] ius_set;
	assign ack_ev  = intr_ack_in & ~ack_q;
	assign ius_rst = wr_go & ~is_data & (cur_idx == sch_pkg::REG_PTR)
		& (pwdata[sch_pkg::CMD_LO +: 3] == sch_pkg::CMD_RST_IUS);
	assign ius_set = (ack_ev & daisy_chain_in & master[sch_pkg::MASTER_INTR_ENABLE]) ? ip_top : 6'h00;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_q <= 1'b0;
			intr_under_service_bit <= '0;
			intr_vector_out <= '0;
		end else begin
			ack_q <= intr_ack_in;
			intr_under_service_bit <= (intr_under_service_bit & ~(ius_rst ? top_of(intr_under_service_bit) : 6'h00)) | ius_set;
			if (ack_ev)
				intr_vector_out <= master[sch_pkg::VIS] ? {vec[7:4], cur_status, vec[0]} : vec;
		end
	end

	// Request and chain; a pending request waits while anything is in service
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intr_n <= 1'b1;
			daisy_chain_out <= 1'b0;
		end else begin
			intr_n <= ~(master[sch_pkg::MASTER_INTR_ENABLE] & daisy_chain_in & (|ip_all) & ~(|intr_under_service_bit));
			daisy_chain_out <= daisy_chain_in & ~(|intr_under_service_bit);
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic       ch_wr, ch_rd, ctl_acc, ptr_wr;
		logic [2:0] cmd;
		logic [7:0] ptr, intr_ctl, rxctl, coding, misc, extie;
		assign ch_wr   = wr_go & (cur_ch == c[0]);
		assign ch_rd   = rd_go & (cur_ch == c[0]);
		assign ctl_acc = (ch_wr | ch_rd) & ~is_data;
		assign ptr_wr  = ch_wr & ~is_data & (cur_idx == sch_pkg::REG_PTR);
		assign cmd     = ptr_wr ? pwdata[sch_pkg::CMD_LO +: 3] : 3'h0;

		// Channel configuration; the pointer self-clears after its indirect access
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ptr <= sch_pkg::REG_RESET;
				intr_ctl <= sch_pkg::REG_RESET;
				rxctl <= sch_pkg::REG_RESET;
				coding <= sch_pkg::REG_RESET;
				misc <= sch_pkg::REG_RESET;
				extie <= sch_pkg::REG_RESET;
			end else begin
				if (ptr_wr)
					ptr <= pwdata[7:0];
				else if (ctl_acc)
					ptr <= ptr & sch_pkg::PTR_KEEP;
				if (ch_wr && !is_data) begin
					case (cur_idx)
						sch_pkg::REG_INTR:   intr_ctl <= pwdata[7:0];
						sch_pkg::REG_RXCTL:  rxctl <= pwdata[7:0];
						sch_pkg::REG_CODING: coding <= pwdata[7:0];
						sch_pkg::REG_MISC:   misc <= pwdata[7:0];
						sch_pkg::REG_EXTIE:  extie <= pwdata[7:0];
						default: ;
					endcase
				end
			end
		end
		assign ptr_v[c] = ptr;
		assign extie_v[c] = extie;

		logic [1:0] code;
		logic       loop, echo, tx_ok, rx_ok;
		assign code  = coding[sch_pkg::CODE_LO +: 2];
		assign loop  = misc[sch_pkg::LOOP];
		assign echo  = misc[sch_pkg::ECHO];
		assign tx_ok = rxctl[sch_pkg::TX_EN] & (cts_v[c] | ~rxctl[sch_pkg::AUTO_EN] | loop);
		assign rx_ok = rxctl[sch_pkg::RX_EN] & (cd_v[c] | ~rxctl[sch_pkg::AUTO_EN] | loop);

		// Transmitter: start, eight data bits LSB first, stop, coded per cell
		localparam int CNT_W_T = sch_pkg::CNT_W;
		logic [CNT_W_T-1:0] tx_cnt;
		logic [8:0] tx_sh;
		logic [3:0] tx_left;
		logic [7:0] tx_buf;
		logic       tx_full, tx_written, tx_bit, tx_line, tx_act, tx_empty_ev, under_ev, zc_ev;
		assign zc_ev = (tx_cnt == sch_pkg::CELL_LAST);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tx_cnt <= '0;
				tx_sh <= '1;
				tx_left <= '0;
				tx_buf <= '0;
				tx_full <= 1'b0;
				tx_written <= 1'b0;
				tx_bit <= 1'b1;
				tx_line <= 1'b1;
				tx_act <= 1'b0;
				tx_empty_ev <= 1'b0;
				under_ev <= 1'b0;
			end else begin
				tx_empty_ev <= 1'b0;
				under_ev <= 1'b0;
				tx_cnt <= zc_ev ? '0 : tx_cnt + 1'b1;
				if (tx_cnt == '0) begin
					if (tx_left != '0) begin
						tx_bit <= tx_sh[0];
						tx_line <= enc(code, 1'b1, tx_sh[0], tx_line);
						tx_sh <= {1'b1, tx_sh[8:1]};
						tx_left <= tx_left - 1'b1;
					end else if (tx_full && tx_ok) begin
						tx_bit <= 1'b0;
						tx_line <= enc(code, 1'b1, 1'b0, tx_line);
						tx_sh <= {1'b1, tx_buf};
						tx_left <= sch_pkg::TX_FRAME_REST;
						tx_act <= 1'b1;
						tx_empty_ev <= 1'b1;
					end else begin
						tx_bit <= 1'b1;
						tx_line <= enc(code, 1'b1, 1'b1, tx_line);
						tx_act <= 1'b0;
						under_ev <= tx_act; // Once per run that drains dry
					end
				end else if (tx_cnt == sch_pkg::CELL_HALF) begin
					tx_line <= enc(code, 1'b0, tx_bit, tx_line);
				end
				if (ch_wr && is_data) begin
					tx_buf <= pwdata[7:0];
					tx_written <= 1'b1;
				end
				if (ch_wr && is_data)
					tx_full <= 1'b1;
				else if (tx_cnt == '0 && tx_left == '0 && tx_ok)
					tx_full <= 1'b0;
			end
		end

		// Serial output: echo modes bypass the transmitter entirely
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				txd_v[c] <= 1'b1;
			else
				txd_v[c] <= (echo | loop) ? rxd_v[c] : tx_line;
		end

		// Receiver: locks cell timing on an edge, samples at quarter and three quarters
		sch_pkg::sch_rx_state_t rx_st;
		logic [CNT_W_T-1:0] rx_cnt;
		logic       rx_src, rx_q, locked, s1, last_s1, dbit;
		logic [3:0] rx_idx;
		logic [7:0] rx_sh, rx_buf;
		logic       rx_avail, char_ev, ovr_ev, frm_ev, brk, brk_ev;
		assign rx_src = loop ? tx_line : rxd_v[c];
		always_comb begin
			case (code)
				sch_pkg::CODE_NRZ:  dbit = s1;
				sch_pkg::CODE_NRZI: dbit = (s1 == last_s1);
				sch_pkg::CODE_MARK: dbit = (s1 != rx_src);
				default:            dbit = (s1 == rx_src);
			endcase
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rx_st <= sch_pkg::RX_HUNT;
				rx_cnt <= '0;
				rx_q <= 1'b1;
				locked <= 1'b0;
				s1 <= 1'b1;
				last_s1 <= 1'b1;
				rx_idx <= '0;
				rx_sh <= '0;
				rx_buf <= '0;
				rx_avail <= 1'b0;
				char_ev <= 1'b0;
				ovr_ev <= 1'b0;
				frm_ev <= 1'b0;
				brk <= 1'b0;
				brk_ev <= 1'b0;
			end else begin
				char_ev <= 1'b0;
				ovr_ev <= 1'b0;
				frm_ev <= 1'b0;
				brk_ev <= 1'b0;
				rx_q <= rx_src;
				rx_cnt <= (rx_cnt == sch_pkg::CELL_LAST) ? '0 : rx_cnt + 1'b1;
				if (!rx_ok) begin
					locked <= 1'b0;
					rx_st <= sch_pkg::RX_HUNT;
				end else if (rx_st == sch_pkg::RX_HUNT && rx_src != rx_q
						&& (!locked || (code[1] == 1'b0 && !misc[sch_pkg::BIPHASE_RX]))) begin
					rx_cnt <= '0;
					locked <= 1'b1;
				end else if (locked && rx_cnt == sch_pkg::CELL_Q1) begin
					s1 <= rx_src;
				end else if (locked && rx_cnt == sch_pkg::CELL_Q3) begin
					last_s1 <= s1;
					if (dbit && brk) begin
						brk <= 1'b0;
						brk_ev <= 1'b1;
					end
					case (rx_st)
						sch_pkg::RX_HUNT: begin
							rx_idx <= '0;
							if (!dbit)
								rx_st <= sch_pkg::RX_DATA;
						end
						sch_pkg::RX_DATA: begin
							if (rx_idx == sch_pkg::RX_STOP_IDX) begin
								rx_st <= sch_pkg::RX_HUNT;
								rx_buf <= rx_sh;
								rx_avail <= 1'b1;
								char_ev <= 1'b1;
								ovr_ev <= rx_avail;
								frm_ev <= ~dbit;
								if (!dbit && rx_sh == '0 && !brk) begin
									brk <= 1'b1;
									brk_ev <= 1'b1;
								end
							end else begin
								rx_sh <= {dbit, rx_sh[7:1]};
								rx_idx <= rx_idx + 1'b1;
							end
						end
						default: rx_st <= sch_pkg::RX_HUNT;
					endcase
				end
				if (ch_rd && is_data && !(locked && rx_cnt == sch_pkg::CELL_Q3
						&& rx_st == sch_pkg::RX_DATA && rx_idx == sch_pkg::RX_STOP_IDX))
					rx_avail <= 1'b0;
			end
		end

		// External events; line-level pins still interrupt in loopback
		logic cd_q, syn_q, ext_ev;
		assign ext_ev = ((cd_v[c] ^ cd_q) & extie[sch_pkg::CD_IE])
			| ((syn_v[c] ^ syn_q) & extie[sch_pkg::SYNC_IE])
			| (under_ev & extie[sch_pkg::UNDER_IE])
			| (zc_ev & extie[sch_pkg::ZC_IE])
			| (brk_ev & extie[sch_pkg::BREAK_IE]);

		// Pending bits; a new event in the clearing cycle keeps its bit
		logic ip_rx, ip_tx, ip_ext, sp_lat, armed, sp_ev, rx_set, rx_clr;
		logic [1:0] rxm;
		assign rxm = intr_ctl[sch_pkg::RXM_LO +: 2];
		assign sp_ev = ovr_ev | frm_ev;
		always_comb begin
			case (rxm)
				sch_pkg::RXM_FIRST:   rx_set = (char_ev & armed) | (sp_ev & ~armed);
				sch_pkg::RXM_ALL:     rx_set = char_ev | sp_ev;
				sch_pkg::RXM_SPECIAL: rx_set = sp_ev;
				default:              rx_set = 1'b0;
			endcase
		end
		assign rx_clr = (ch_rd & is_data & ~sp_lat) | (cmd == sch_pkg::CMD_ERR_RST);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cd_q <= 1'b0;
				syn_q <= 1'b0;
				ip_rx <= 1'b0;
				ip_tx <= 1'b0;
				ip_ext <= 1'b0;
				sp_lat <= 1'b0;
				armed <= 1'b1;
			end else begin
				cd_q <= cd_v[c];
				syn_q <= syn_v[c];
				if (rx_set)
					ip_rx <= 1'b1;
				else if (rx_clr)
					ip_rx <= 1'b0;
				if (tx_empty_ev && tx_written && intr_ctl[sch_pkg::TX_IE])
					ip_tx <= 1'b1;
				else if ((ch_wr && is_data) || cmd == sch_pkg::CMD_RST_TXP)
					ip_tx <= 1'b0;
				if (ext_ev && intr_ctl[sch_pkg::EXT_IE])
					ip_ext <= 1'b1;
				else if (cmd == sch_pkg::CMD_RST_EXT)
					ip_ext <= 1'b0;
				if (sp_ev)
					sp_lat <= 1'b1;
				else if (cmd == sch_pkg::CMD_ERR_RST)
					sp_lat <= 1'b0;
				if (rxm == sch_pkg::RXM_FIRST && char_ev && armed)
					armed <= 1'b0;
				else if (cmd == sch_pkg::CMD_EN_FIRST)
					armed <= 1'b1;
			end
		end
		assign ip_v[c] = {ip_rx, ip_tx, ip_ext};
		assign sp_v[c] = sp_lat;
		assign rxbuf_v[c] = rx_buf;
		assign rr0_v[c] = {brk, under_ev, cts_v[c], syn_v[c], cd_v[c], ~tx_full, zc_ev, rx_avail};
		assign rr1_v[c] = {1'b0, sp_lat & frm_ev, sp_lat, 4'h0, ~tx_full & (tx_left == '0)};

		// Wait/request: request when ready, wait while a data access is not ready
		logic ready, wr_en, is_req;
		assign ready   = intr_ctl[sch_pkg::WREQ_ON_RX] ? rx_avail : ~tx_full;
		assign wr_en   = intr_ctl[sch_pkg::WREQ_EN];
		assign is_req  = intr_ctl[sch_pkg::WREQ_FUNC];
		assign stall_v[c] = wr_en & ~is_req & ~ready;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				wrn_v[c] <= 1'b1;
			else if (is_req)
				wrn_v[c] <= ~(wr_en & ready);
			else
				wrn_v[c] <= ~(wr_en & ~ready & psel & is_data & (cur_ch == c[0]));
		end
	end
endmodule : sch_top
`default_nettype wire

//--- dv/sch_top_sva.sv
// Checker for the bus and interrupt ports of sch_top.
// Assumes one clock domain, pclk, with presetn as its reset.
`default_nettype none
module sch_top_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        intr_ack_in,
	input wire logic        daisy_chain_in,
	input wire logic        daisy_chain_out,
	input wire logic        intr_n,
	input wire logic [7:0]  intr_vector_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	property p_cause; pready |-> $past(psel && penable); endproperty
	a_cause: assert property (p_cause) else $error("pready unasked");
	property p_pad; pready |-> prdata[31:8] == 24'h0; endproperty
	a_pad: assert property (p_pad) else $error("upper read bits");
	property p_err; pready |-> pslverr == ((paddr & sch_pkg::ADDR_MAP_MASK) != 32'h0); endproperty
	a_err: assert property (p_err) else $error("bad error flag");
	property p_chain; daisy_chain_out |-> $past(daisy_chain_in); endproperty
	a_chain: assert property (p_chain) else $error("chain out high");
	property p_req; $fell(intr_n) |-> $past(daisy_chain_in); endproperty
	a_req: assert property (p_req) else $error("request blocked");
	property p_ack; $rose(intr_ack_in) && !intr_n |-> ##2 (intr_n && !daisy_chain_out); endproperty
	a_ack: assert property (p_ack) else $error("ack not served");
	property p_vec; $changed(intr_vector_out) |-> $past(intr_ack_in) && !$past(intr_ack_in, 2); endproperty
	a_vec: assert property (p_vec) else $error("vector moved");
	c_ack: cover property ($rose(intr_ack_in) && !intr_n);
	c_err: cover property (pready && pslverr);
	c_req: cover property ($fell(intr_n));
endmodule : sch_top_chk
bind sch_top sch_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .intr_ack_in(intr_ack_in),
	.daisy_chain_in(daisy_chain_in), .daisy_chain_out(daisy_chain_out), .intr_n(intr_n),
	.intr_vector_out(intr_vector_out));
`default_nettype wire

//--- dv/sch_line_peer.sv
// Far end of a serial line: one frame per send pulse.
// Assumes pclk and a cell of sch_pkg::CELL_CYC cycles.
`default_nettype none
module sch_line_peer (
	input  wire logic       pclk,
	input  wire logic       send,
	input  wire logic [7:0] byte_in,
	output logic            line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] sh = 10'h3ff;
	int         cnt = 0;
	int         left = 0;
	// Start, data LSB first, stop; a send during a frame is dropped
	always @(posedge pclk) begin
		if (send && left == 0) begin
			sh <= {1'b1, byte_in, 1'b0};
			left <= 10;
			cnt <= 0;
		end else if (left != 0 && cnt == sch_pkg::CELL_CYC - 1) begin
			sh <= {1'b1, sh[9:1]};
			left <= left - 1;
			cnt <= 0;
		end else if (left != 0) begin
			cnt <= cnt + 1;
		end
	end
	assign line = (left != 0) ? sh[0] : 1'b1; // Idle high, as if pulled up
endmodule : sch_line_peer
`default_nettype wire

//--- dv/sch_top_tb.sv
// Bench for sch_top: registers, echo, receive interrupt, acknowledge.
// Assumes the line peer feeds both receive inputs.
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; $display("unexpected %0t %h", $time, a); end end
module sch_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ack, dci, dco, intr_n, send, line, txa, wa, er;
	logic        txb, wb;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [7:0]  vec;
	logic [5:0]  pins;
	logic [9:0]  fr = 10'h278;
	int          failures = 0, n_tests = 0, cyc = 0;
	logic [27:0] rows [11] = '{28'h0880200, 28'h088a000, 28'h0880f00, 28'h0880800, 28'h0880200, 28'h08400a0,
		28'h0080200, 28'h00400a6, 28'h0880f00, 28'h0840008, 28'h1020000};
	logic [15:0] cfg [10] = '{16'h0003, 16'h0001, 16'h0001, 16'h0010, 16'h0009, 16'h0009, 16'h080e, 16'h0808,
		16'h0801, 16'h0801};
	sch_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in_a(line), .rxd_in_b(line),
		.txd_out_a(txa), .txd_out_b(txb), .carrier_detect_in_a(pins[0]), .carrier_detect_in_b(pins[1]),
		.cts_in_a(pins[2]), .cts_in_b(pins[3]), .sync_pin_a(pins[4]), .sync_pin_b(pins[5]), .intr_ack_in(ack),
		.daisy_chain_in(dci), .daisy_chain_out(dco), .intr_n(intr_n), .intr_vector_out(vec), .wait_req_n_a(wa),
		.wait_req_n_b(wb));
	sch_line_peer peer (.pclk(pclk), .send(send), .byte_in(8'h3c), .line(line));
	// Clock, 20 ns
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Hang guard, well above the roughly 1200 cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	// One transfer, held until pready is seen high
	task automatic apb(input logic [31:0] a, input logic w, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	initial begin
		{presetn, psel, penable, pwrite, ack, send, paddr, pwdata} = '0;
		dci = 1'b1;
		pins = 6'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK({intr_n, txa, txb, wa, wb, dco}, 6'h3f)
		// Rows: address, write/check/error flags, data, expected read
		foreach (rows[i]) begin
			apb({24'h0, rows[i][27:20]}, rows[i][19], rows[i][15:8]);
			if (rows[i][18])
				`CHK(rd[7:0], rows[i][7:0])
			`CHK(er, rows[i][17])
		end
		// B receives every character, A echoes with its transmit interrupts left off, A external enabled
		foreach (cfg[i])
			apb({24'h0, cfg[i][15:8]}, 1'b1, cfg[i][7:0]);
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
		repeat (sch_pkg::CELL_CYC / 2) @(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			`CHK(txa, fr[i])
			repeat (sch_pkg::CELL_CYC) @(posedge pclk);
		end
		for (int k = 0; k < 400 && intr_n !== 1'b0; k++)
			@(posedge pclk);
		`CHK(intr_n, 1'b0)
		apb(32'h8, 1'b1, 8'h03);
		apb(32'h8, 1'b0, 8'h00);
		`CHK(rd[7:0], 8'h04)
		ack <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK({vec, intr_n, dco}, 10'h292)
		ack <= 1'b0;
		apb(32'h4, 1'b0, 8'h00);
		`CHK(rd[7:0], 8'h3c)
		apb(32'h0, 1'b1, 8'h38);
		@(posedge pclk);
		`CHK(dco, 1'b1)
		pins <= 6'h3f;
		dci <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK({intr_n, dco}, 2'b10)
		// Carrier edge on A left a pending bit that the low chain input held back
		apb(32'h8, 1'b1, 8'h03);
		apb(32'h8, 1'b0, 8'h00);
		`CHK(rd[7:0], 8'h08)
		dci <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK({intr_n, dco}, 2'b01)
		// B as request line asks for data while its transmit buffer is empty
		apb(32'h0, 1'b1, 8'h01);
		apb(32'h0, 1'b1, 8'hd0);
		@(posedge pclk);
		`CHK(wb, 1'b0)
		print_verdict();
	end
endmodule : sch_top_tb
`default_nettype wire
